// ===== pkg/adcc_pkg.sv
// Behaviour
// - compare off, every finished conversion sets the done flag (bit 7).
// - compare on, done flag sets only when compare result is true.
// - writing status/control or reading result low byte clears the done flag.
// - software cannot write the done flag directly; it is read-only.
// - done flag set with irq enable (bit 6) high raises the interrupt if interrupt mask bit 0 is set.
// - continuous off: one conversion after write or hardware trigger.
// - continuous on (bit 5): back-to-back conversions after write or trigger.
// - channel select is five bits, bits 4:0 of status/control.
// - codes 0-7 pick inputs 0-7, codes 16-23 pick inputs 16-23.
// - all-ones channel code powers converter off and isolates the input.
// - all-ones write stops continuous mode with no extra single conversion.
// - without continuous mode, low power is entered after each conversion.
package adcc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_SC1 = 4'h0;
  localparam logic [3:0] ADDR_CFG = 4'h1;
  localparam logic [3:0] ADDR_RESL = 4'h2;
  localparam logic [3:0] ADDR_RESH = 4'h3;
  localparam logic [3:0] ADDR_CMP = 4'h4;
  localparam logic [3:0] ADDR_IST = 4'h5;
  localparam logic [3:0] ADDR_IMSK = 4'h6;
  localparam logic [3:0] ADDR_STAT = 4'h7;
  // field positions
  localparam int BIT_DONE = 7;
  localparam int BIT_IEN = 6;
  localparam int BIT_CONT = 5;
  localparam int BIT_HWTRG = 0;
  localparam int BIT_CMPEN = 1;
  localparam int BIT_CMPGT = 2;
  localparam logic [4:0] CH_OFF = 5'h1f;
  localparam logic [4:0] CH_RST = 5'h1f;
  localparam logic [7:0] ZERO8 = 8'h00;
  // conversion time
  localparam int CONV_NS = 1000;
  localparam int CLK_NS = 50;
  localparam int CONV_CYC_I = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] CONV_CYC = 8'(CONV_CYC_I);
  localparam int RES_W = 10;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_MISS = 1;

  typedef enum logic [1:0] {
    ADCC_OFF = 2'b00,
    ADCC_IDLE = 2'b01,
    ADCC_CONV = 2'b10
  } adcc_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcc_bus_t;

  // decode a legal channel code
  function automatic logic adcc_ch_valid(input logic [4:0] ch);
    adcc_ch_valid = (ch[4:3] == 2'b00) || (ch[4:3] == 2'b10);
  endfunction
endpackage

// ===== verilog/adcc_ctrl.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module adcc_ctrl
  import adcc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire adcc_bus_t i_bus,
  output logic [7:0] o_rdata,
  input wire logic i_hw_trigger,
  input wire logic [RES_W-1:0] i_sar_result,
  output logic o_sar_start,
  output logic o_power_on,
  output logic o_input_connect,
  output logic [4:0] o_channel,
  output logic o_irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic conversion_done_flag;
  logic done_irq_enable;
  logic continuous_enable;
  logic [4:0] channel_select;
  logic hw_trig_mode;
  logic cmp_enable;
  logic cmp_greater;
  logic [7:0] cmp_value;
  logic [RES_W-1:0] result;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [7:0] conv_cnt;
  logic hwt_meta;
  logic hwt_sync;
  logic hwt_prev;
  logic pending;
  adcc_state_t state;
  logic sc1_wr;
  logic resl_rd;
  logic hwt_edge;
  logic conv_end;
  logic cmp_true;
  logic set_done;
  logic start_now;
  logic [7:0] next_rdata;

  assign sc1_wr = i_bus.wr && (i_bus.addr == ADDR_SC1);
  assign resl_rd = i_bus.rd && (i_bus.addr == ADDR_RESL);
  assign hwt_edge = hwt_sync && !hwt_prev;
  assign conv_end = (state == ADCC_CONV) && (conv_cnt == ZERO8);
  // compare against the upper 8 result bits
  assign cmp_true = cmp_greater ? (i_sar_result[RES_W-1:2] >= cmp_value)
                                : (i_sar_result[RES_W-1:2] < cmp_value);
  assign set_done = conv_end && (!cmp_enable || cmp_true);
  assign start_now = hw_trig_mode ? hwt_edge : pending;

  // ---------------------------------------------------------------
  // trigger input synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      hwt_meta <= 1'b0;
      hwt_sync <= 1'b0;
      hwt_prev <= 1'b0;
    end else begin
      hwt_meta <= i_hw_trigger;
      hwt_sync <= hwt_meta;
      hwt_prev <= hwt_sync;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      done_irq_enable <= 1'b0;
      continuous_enable <= 1'b0;
      channel_select <= CH_RST;
      hw_trig_mode <= 1'b0;
      cmp_enable <= 1'b0;
      cmp_greater <= 1'b0;
      cmp_value <= ZERO8;
      irq_mask <= 2'b00;
    end else if (i_bus.wr) begin
      case (i_bus.addr)
        ADDR_SC1: begin
          // done flag bit ignored here
          done_irq_enable <= i_bus.wdata[BIT_IEN];
          continuous_enable <= i_bus.wdata[BIT_CONT];
          channel_select <= i_bus.wdata[4:0];
        end
        ADDR_CFG: begin
          hw_trig_mode <= i_bus.wdata[BIT_HWTRG];
          cmp_enable <= i_bus.wdata[BIT_CMPEN];
          cmp_greater <= i_bus.wdata[BIT_CMPGT];
        end
        ADDR_CMP: cmp_value <= i_bus.wdata;
        ADDR_IMSK: irq_mask <= i_bus.wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // software start request
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      pending <= 1'b0;
    end else if (sc1_wr) begin
      pending <= (i_bus.wdata[4:0] != CH_OFF);
    end else if (start_now || hw_trig_mode) begin
      pending <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      state <= ADCC_OFF;
      conv_cnt <= ZERO8;
    end else if (sc1_wr && (i_bus.wdata[4:0] == CH_OFF)) begin
      state <= ADCC_OFF;
      conv_cnt <= ZERO8;
    end else begin
      case (state)
        ADCC_OFF, ADCC_IDLE: begin
          if (start_now && adcc_ch_valid(channel_select)) begin
            state <= ADCC_CONV;
            conv_cnt <= CONV_CYC - 8'h01;
          end else if (channel_select != CH_OFF) begin
            state <= ADCC_IDLE;
          end
        end
        ADCC_CONV: begin
          if (conv_cnt != ZERO8) begin
            conv_cnt <= conv_cnt - 8'h01;
          end else if (continuous_enable) begin
            conv_cnt <= CONV_CYC - 8'h01;
          end else begin
            state <= ADCC_OFF;
          end
        end
        default: state <= ADCC_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // result and done flag
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      result <= '0;
    end else if (conv_end) begin
      result <= i_sar_result;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      conversion_done_flag <= 1'b0;
    end else if (set_done) begin
      conversion_done_flag <= 1'b1; // set wins
    end else if (sc1_wr || resl_rd) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, write one to clear
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      irq_status <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (i == IRQ_DONE && set_done && done_irq_enable) begin
          irq_status[i] <= 1'b1;
        end else if (i == IRQ_MISS && set_done && conversion_done_flag) begin
          irq_status[i] <= 1'b1; // result overwritten unread
        end else if (i_bus.wr && i_bus.addr == ADDR_IST && i_bus.wdata[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = ZERO8;
    case (i_bus.addr)
      ADDR_SC1: next_rdata = {conversion_done_flag, done_irq_enable,
                              continuous_enable, channel_select};
      ADDR_CFG: next_rdata = {5'h00, cmp_greater, cmp_enable, hw_trig_mode};
      ADDR_RESL: next_rdata = result[7:0];
      ADDR_RESH: next_rdata = {6'h00, result[RES_W-1:8]};
      ADDR_CMP: next_rdata = cmp_value;
      ADDR_IST: next_rdata = {6'h00, irq_status};
      ADDR_IMSK: next_rdata = {6'h00, irq_mask};
      ADDR_STAT: next_rdata = {6'h00, state};
      default: next_rdata = ZERO8;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_rdata <= ZERO8;
    end else begin
      o_rdata <= i_bus.rd ? next_rdata : ZERO8;
    end
  end

  // ---------------------------------------------------------------
  // analog side controls
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_sar_start <= 1'b0;
      o_power_on <= 1'b0;
      o_input_connect <= 1'b0;
      o_channel <= CH_RST;
    end else begin
      o_sar_start <= (state != ADCC_CONV) && start_now && adcc_ch_valid(channel_select);
      o_power_on <= (state == ADCC_CONV);
      o_input_connect <= (state == ADCC_CONV) && adcc_ch_valid(channel_select);
      o_channel <= channel_select;
    end
  end
endmodule

// ===== sim/adcc_ctrl_monitor.sv
`timescale 1ns/1ps
module adcc_ctrl_monitor
  import adcc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire adcc_bus_t i_bus,
  input wire logic [7:0] o_rdata,
  input wire logic i_hw_trigger,
  input wire logic [RES_W-1:0] i_sar_result,
  input wire logic o_sar_start,
  input wire logic o_power_on,
  input wire logic o_input_connect,
  input wire logic [4:0] o_channel,
  input wire logic o_irq
);
  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  rdata_idle_a: assert property (!i_bus.rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_rd_a: assert property (i_bus.rd && i_bus.addr > ADDR_STAT |=> o_rdata == 8'h00)
    else $error("unmapped read returned data");
  chan_copy_a: assert property (i_bus.wr && i_bus.addr == ADDR_SC1 |->
    ##2 o_channel == $past(i_bus.wdata[4:0], 2)) else $error("channel output not written");
  bad_chan_a: assert property (o_channel[3] |-> !o_sar_start)
    else $error("conversion started on illegal channel");
  start_pulse_a: assert property (o_sar_start |=> !o_sar_start)
    else $error("start pulse longer than one cycle");
  conv_len_a: assert property (o_sar_start |-> ##2 o_power_on [*8])
    else $error("converter powered down mid conversion");
  connect_pwr_a: assert property (o_input_connect |-> o_power_on)
    else $error("input connected while powered down");
  off_code_a: assert property ((o_channel == CH_OFF) [*2] |-> !o_power_on && !o_input_connect)
    else $error("converter active with off code");
endmodule

bind adcc_ctrl adcc_ctrl_monitor mon (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_bus(i_bus),
  .o_rdata(o_rdata), .i_hw_trigger(i_hw_trigger), .i_sar_result(i_sar_result),
  .o_sar_start(o_sar_start), .o_power_on(o_power_on), .o_input_connect(o_input_connect),
  .o_channel(o_channel), .o_irq(o_irq));

// ===== sim/adcc_ctrl_tb.sv
`timescale 1ns/1ps
module adcc_ctrl_tb
  import adcc_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  adcc_bus_t i_bus = '0;
  logic i_hw_trigger = 1'b0;
  logic [RES_W-1:0] i_sar_result = 10'h2a5;
  logic [7:0] o_rdata;
  logic [7:0] d;
  logic o_sar_start, o_power_on, o_input_connect, o_irq;
  logic [4:0] o_channel;
  int bad_count = 0;
  int total_checks = 0;
  // ---------------------------------------------------------------
  // clock, design and bus tasks
  // ---------------------------------------------------------------
  always #25 i_mclk = ~i_mclk;
  adcc_ctrl uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_hw_trigger(i_hw_trigger), .i_sar_result(i_sar_result), .o_sar_start(o_sar_start),
    .o_power_on(o_power_on), .o_input_connect(o_input_connect), .o_channel(o_channel),
    .o_irq(o_irq));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    i_bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_mclk);
    i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    i_bus.rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // poll status until the done flag shows, bounded
  task automatic wait_done();
    int n = 0;
    d = 8'h00;
    while (d[7] !== 1'b1) begin
      rd(ADDR_SC1, d);
      n++;
      if (n > 60) begin
        bad_count++;
        report_and_stop();
      end
    end
  endtask
  // scenario sequence
  initial begin
    repeat (3) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rd(ADDR_SC1, d);
    chk(d, 8'h1f);
    rd(4'h9, d);
    chk(d, 8'h00);
    wr(ADDR_IMSK, 8'h01);
    wr(ADDR_SC1, 8'h43);
    wait_done();
    chk(d, 8'hc3);
    chk({7'h0, o_irq}, 8'h01);
    chk({7'h0, o_power_on}, 8'h00);
    idle(30);
    chk({7'h0, o_power_on}, 8'h00);
    wr(ADDR_IMSK, 8'h00);
    rd(ADDR_RESH, d);
    chk(d, 8'h02);
    chk({7'h0, o_irq}, 8'h00);
    wr(ADDR_IMSK, 8'h01);
    rd(ADDR_RESL, d);
    chk(d, 8'ha5);
    chk({7'h0, o_irq}, 8'h01);
    rd(ADDR_SC1, d);
    chk(d, 8'h43);
    wr(ADDR_IST, 8'h01);
    rd(ADDR_IST, d);
    chk({d[0], o_irq}, 8'h00);
    // flag write ignored, interrupt enable off
    wr(ADDR_SC1, 8'h97);
    rd(ADDR_SC1, d);
    chk(d, 8'h17);
    wait_done();
    chk({d[7:5], o_channel}, 8'h97);
    chk({7'h0, o_irq}, 8'h00);
    // compare false, then true
    wr(ADDR_CMP, 8'h10);
    wr(ADDR_CFG, 8'h02);
    wr(ADDR_SC1, 8'h03);
    idle(40);
    rd(ADDR_SC1, d);
    chk(d, 8'h03);
    wr(ADDR_CFG, 8'h06);
    wr(ADDR_SC1, 8'h03);
    wait_done();
    chk(d, 8'h83);
    // hardware trigger mode ignores the write
    wr(ADDR_CFG, 8'h01);
    wr(ADDR_SC1, 8'h05);
    idle(40);
    i_hw_trigger <= 1'b1;
    rd(ADDR_SC1, d);
    chk(d, 8'h05);
    wait_done();
    chk(d, 8'h85);
    idle(1);
    i_hw_trigger <= 1'b0;
    // continuous run, stopped by off code mid conversion
    wr(ADDR_CFG, 8'h00);
    wr(ADDR_SC1, 8'h21);
    wait_done();
    // flag left unread, next result overwrites it
    idle(25);
    rd(ADDR_IST, d);
    chk(d, 8'h02);
    rd(ADDR_RESL, d);
    wait_done();
    chk(d, 8'ha1);
    idle(12);
    wr(ADDR_SC1, 8'h3f);
    idle(3);
    chk({o_power_on, o_input_connect, o_channel}, 8'h1f);
    idle(40);
    rd(ADDR_SC1, d);
    chk(d, 8'h3f);
    wr(ADDR_SC1, 8'h08);
    idle(40);
    rd(ADDR_SC1, d);
    chk(d, 8'h08);
    report_and_stop();
  end
endmodule
